// file: inc/fcc_params.svh
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH

// Clock rate and derived timing counts
`define FCC_CLK_MHZ 40
`define FCC_POR_US 16
`define FCC_POR_CYC (`FCC_POR_US * `FCC_CLK_MHZ)
`define FCC_TICK_US 1
`define FCC_TICK_CYC (`FCC_TICK_US * `FCC_CLK_MHZ)
`define FCC_DONE_HOLD_TICKS 2
`define FCC_MCLK_HALF 10
`define FCC_CFG_BITS 64

// Register offsets
`define FCC_OFS_CTRL 8'h00
`define FCC_OFS_STAT 8'h04
`define FCC_OFS_RBCNT 8'h08

// Control fields and reset value
`define FCC_CTRL_RB_BLOCK 0
`define FCC_CTRL_RECFG 1
`define FCC_CTRL_RST 1'h0

// Option bits carried at the head of the bitstream
`define FCC_OPT_RB_LO 0
`define FCC_OPT_PU 2

// Bus responses
`define FCC_RESP_OKAY 2'h0
`define FCC_RESP_SLVERR 2'h2

`endif

// file: inc/fcc_pkg.sv
package fcc_pkg;
  typedef enum {
    ST_POR, ST_WAIT_RST, ST_SAMPLE, ST_LOAD,
    ST_IO_ON, ST_DONE_ON, ST_RUN, ST_RDBK
  } fcc_state_t;

  typedef enum logic [2:0] {
    MD_MASTER_SET = 3'h0, MD_MASTER_LOW = 3'h4, MD_PERIPH = 3'h5,
    MD_MASTER_HIGH = 3'h6, MD_SLAVE = 3'h7
  } fcc_mode_t;

  typedef enum logic [1:0] {
    RB_REPEAT = 2'h0, RB_ONCE = 2'h1, RB_OFF = 2'h2, RB_OFF2 = 2'h3
  } fcc_rbopt_t;
endpackage

// file: inc/fcc_mem_if.sv
interface fcc_mem_if;
  logic clr;
  logic wr;
  logic wbit;
  logic wr_last;
  logic rd_start;
  logic rd_step;
  logic rbit;
  logic rd_last;
  logic [2:0] opt;
  modport ctrl(output clr, wr, wbit, rd_start, rd_step,
               input wr_last, rbit, rd_last, opt);
  modport mem(input clr, wr, wbit, rd_start, rd_step,
              output wr_last, rbit, rd_last, opt);
endinterface

// file: design/fcc_sync.sv
module fcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two stages; only the second stage is read outside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RV;
      q <= RV;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: design/fcc_cfg_mem.sv
`include "fcc_params.svh"

module fcc_cfg_mem #(
  parameter int DEPTH = `FCC_CFG_BITS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  fcc_mem_if.mem m
);
  localparam int AW = $clog2(DEPTH);
  logic cells_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [2:0] opt_q;

  // Cells have no reset: a loaded pattern survives power-down
  always_ff @(posedge aclk) begin
    if (m.wr) begin
      cells_q[wp_q] <= m.wbit;
    end
  end

  // Load pointer
  always_ff @(posedge aclk) begin
    if (!aresetn || m.clr) begin
      wp_q <= '0;
    end else if (m.wr) begin
      wp_q <= AW'(wp_q + 1'b1);
    end
  end

  // Option bits are the first bits of the stream
  always_ff @(posedge aclk) begin
    if (!aresetn || m.clr) begin
      opt_q <= 3'h0;
    end else if (m.wr && wp_q < AW'(3)) begin
      opt_q[wp_q[1:0]] <= m.wbit;
    end
  end

  // Readback pointer
  always_ff @(posedge aclk) begin
    if (!aresetn || m.rd_start) begin
      rp_q <= '0;
    end else if (m.rd_step && !m.rd_last) begin
      rp_q <= AW'(rp_q + 1'b1);
    end
  end

  assign m.wr_last = m.wr && (wp_q == AW'(DEPTH - 1));
  assign m.rbit = cells_q[rp_q];
  assign m.rd_last = (rp_q == AW'(DEPTH - 1));
  assign m.opt = opt_q;
endmodule

// file: design/fcc_top.sv
// Functional notes
// - Power-down halts activity, keeps loaded configuration
// - Power-down clears storage, floats outputs, inputs high
// - After power-down, done held low two ticks
// - Reset low delays configuration start
// - Power-on time-out, then sample modes, configure
// - Reset during configuration restarts configuration
// - Reset after configuration clears all storage
// - Config clock driven in master/peripheral, input slave
// - Readback shifts data on host config clock
// - Config clock pin held high by pull-up
// - Done is open-drain, pull-up chosen by option
// - Done rises one cycle after I/O outputs
// - Falling done pin after configuration reconfigures
// - All three mode lines sampled together
// - Rising read trigger starts readback after configuration
// - Bitstream option: repeat, single or no readback
// - Readback data active low on mode line 1
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`include "fcc_params.svh"

module fcc_top
  import fcc_pkg::*;
#(
  parameter int CFG_BITS = `FCC_CFG_BITS,
  parameter int POR_CYC = `FCC_POR_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins
  input wire logic power_down_n,
  input wire logic config_reset_n,
  input wire logic config_data_in,
  input wire logic mode0_read_trigger,
  input wire logic mode_line_2,
  input wire logic mode_line_1_in,
  output logic mode_line_1_out,
  output logic mode_line_1_oe,
  input wire logic config_clock_in,
  output logic config_clock_out,
  output logic config_clock_oe,
  output logic config_clock_pullup_en,
  input wire logic done_program_pin_in,
  output logic done_program_pin_out,
  output logic done_program_pin_oe,
  output logic done_pullup_en,
  // Fabric controls
  output logic io_block_out_en,
  output logic storage_clear
);
  localparam int TICK_CYC = `FCC_TICK_CYC;
  localparam int HOLD_CYC = `FCC_DONE_HOLD_TICKS * TICK_CYC;

  fcc_mem_if mif ();
  fcc_state_t st_q;
  fcc_mode_t mode_q;
  logic [7:0] raw;
  logic [7:0] syn;
  logic pd;
  logic rst_i, din_i, m0_i, m1_i, m2_i, config_clock_i, dp_i;
  logic config_clock_prev_q, m0_prev_q, dp_prev_q, pd_prev_q;
  logic mclk_q;
  logic [7:0] mdiv_q;
  logic config_clock_rise;
  logic [$clog2(POR_CYC+1)-1:0] por_q;
  logic [$clog2(HOLD_CYC+1)-1:0] hold_q;
  logic configured;
  logic done_q;
  logic rb_used_q;
  logic rb_allow;
  logic rb_block_q;
  logic recfg_q;
  logic [15:0] rbcnt_q;
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;

  // Pin inputs pass two flops before use
  assign raw = {power_down_n, config_reset_n, config_data_in, mode0_read_trigger,
                mode_line_1_in, mode_line_2, config_clock_in, done_program_pin_in};
  fcc_sync #(.W(8), .RV(8'hFF)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw),
    .q(syn)
  );

  // Inputs read as high while powered down
  assign pd = ~syn[7];
  assign rst_i = syn[6] | pd;
  assign din_i = syn[5] | pd;
  assign m0_i = syn[4] | pd;
  assign m1_i = syn[3] | pd;
  assign m2_i = syn[2] | pd;
  assign config_clock_i = syn[1] | pd;
  assign dp_i = syn[0] | pd;

  // Edge history of sampled lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_clock_prev_q <= 1'b1;
      m0_prev_q <= 1'b1;
      dp_prev_q <= 1'b1;
      pd_prev_q <= 1'b0;
    end else begin
      config_clock_prev_q <= config_clock_i;
      m0_prev_q <= m0_i;
      dp_prev_q <= dp_i;
      pd_prev_q <= pd;
    end
  end

  // Own configuration clock for master and peripheral modes
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != ST_LOAD) begin
      mdiv_q <= 8'h00;
      mclk_q <= 1'b1;
    end else if (!pd) begin
      if (mdiv_q == 8'(`FCC_MCLK_HALF - 1)) begin
        mdiv_q <= 8'h00;
        mclk_q <= ~mclk_q;
      end else begin
        mdiv_q <= 8'(mdiv_q + 1'b1);
      end
    end
  end

  // Rising edge of whichever clock shifts the stream
  always_comb begin
    if (st_q == ST_LOAD && mode_q != MD_SLAVE) begin
      config_clock_rise = !pd && mdiv_q == 8'(`FCC_MCLK_HALF - 1) && !mclk_q;
    end else begin
      config_clock_rise = config_clock_i && !config_clock_prev_q;
    end
  end

  assign configured = (st_q == ST_RUN) || (st_q == ST_RDBK);
  assign rb_allow = !rb_block_q && mif.opt[1:0] != RB_OFF &&
                    mif.opt[1:0] != RB_OFF2 &&
                    !(mif.opt[1:0] == RB_ONCE && rb_used_q);

  // Power-on time-out counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_q <= '0;
    end else if (st_q == ST_POR && !pd && por_q != POR_CYC[$bits(por_q)-1:0]) begin
      por_q <= $bits(por_q)'(por_q + 1'b1);
    end
  end

  // Configuration sequencer; frozen while powered down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_POR;
    end else if (pd) begin
      st_q <= st_q;
    end else begin
      case (st_q)
        ST_POR: begin
          if (por_q == POR_CYC[$bits(por_q)-1:0]) begin
            st_q <= ST_WAIT_RST;
          end
        end
        ST_WAIT_RST: begin
          if (rst_i) begin
            st_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          st_q <= rst_i ? ST_LOAD : ST_WAIT_RST;
        end
        ST_LOAD: begin
          if (!rst_i) begin
            st_q <= ST_WAIT_RST;
          end else if (mif.wr_last) begin
            st_q <= ST_IO_ON;
          end
        end
        ST_IO_ON: begin
          st_q <= ST_DONE_ON;
        end
        ST_DONE_ON: begin
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (recfg_q || (done_q && dp_prev_q && !dp_i)) begin
            st_q <= ST_WAIT_RST;
          end else if (m0_i && !m0_prev_q && rb_allow) begin
            st_q <= ST_RDBK;
          end
        end
        ST_RDBK: begin
          if (config_clock_rise && mif.rd_last) begin
            st_q <= ST_RUN;
          end
        end
        default: begin
          st_q <= ST_POR;
        end
      endcase
    end
  end

  // Mode lines latched together, one cycle before loading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MD_SLAVE;
    end else if (!pd && st_q == ST_SAMPLE) begin
      mode_q <= fcc_mode_t'({m2_i, m1_i, m0_i});
    end
  end

  // Stream into and out of the configuration store
  assign mif.clr = !pd && st_q == ST_SAMPLE;
  assign mif.wr = !pd && st_q == ST_LOAD && rst_i && config_clock_rise;
  assign mif.wbit = din_i;
  assign mif.rd_start = !pd && st_q == ST_RUN;
  assign mif.rd_step = !pd && st_q == ST_RDBK && config_clock_rise;
  fcc_cfg_mem #(.DEPTH(CFG_BITS)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .m(mif.mem)
  );

  // Readback bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == ST_LOAD) begin
      rb_used_q <= 1'b0;
    end else if (st_q == ST_RDBK) begin
      rb_used_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rbcnt_q <= 16'h0000;
    end else if (st_q == ST_RDBK && config_clock_rise && mif.rd_last) begin
      rbcnt_q <= 16'(rbcnt_q + 1'b1);
    end
  end

  // Done hold after power-down release, in 1-MHz ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || pd) begin
      hold_q <= '0;
    end else if (pd_prev_q) begin
      hold_q <= HOLD_CYC[$bits(hold_q)-1:0];
    end else if (hold_q != '0) begin
      hold_q <= $bits(hold_q)'(hold_q - 1'b1);
    end
  end

  // Done and I/O enables in fixed order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      io_block_out_en <= 1'b0;
    end else begin
      io_block_out_en <= !pd && (st_q == ST_IO_ON || st_q == ST_DONE_ON ||
                         configured);
      // Set with the output enable, so the pin releases one cycle after it
      done_q <= !pd && hold_q == '0 && (st_q == ST_IO_ON || st_q == ST_DONE_ON ||
                configured && !(pd_prev_q));
    end
  end

  // Open-drain done and the pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_program_pin_out <= 1'b0;
      done_program_pin_oe <= 1'b1;
      done_pullup_en <= 1'b1;
      config_clock_out <= 1'b1;
      config_clock_oe <= 1'b0;
      config_clock_pullup_en <= 1'b1;
      mode_line_1_out <= 1'b1;
      mode_line_1_oe <= 1'b0;
    end else begin
      done_program_pin_out <= 1'b0;
      done_program_pin_oe <= !pd && !done_q;
      done_pullup_en <= (configured || st_q == ST_DONE_ON) ? mif.opt[`FCC_OPT_PU] : 1'b1;
      config_clock_out <= mclk_q;
      config_clock_oe <= !pd && st_q == ST_LOAD && mode_q != MD_SLAVE;
      config_clock_pullup_en <= 1'b1;
      mode_line_1_out <= ~mif.rbit;
      mode_line_1_oe <= !pd && st_q == ST_RDBK;
    end
  end

  // Storage clear while powered down, unconfigured or reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      storage_clear <= 1'b1;
    end else begin
      storage_clear <= pd || !configured || !rst_i;
    end
  end

  // Write channel capture, either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Ready flags reopen once the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[7:2] <= 6'h02) ? `FCC_RESP_OKAY : `FCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register; reconfigure request clears when acted on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_block_q <= `FCC_CTRL_RST;
      recfg_q <= `FCC_CTRL_RST;
    end else begin
      if (wr_fire && {awaddr_q[7:2], 2'b00} == `FCC_OFS_CTRL && wstrb_q[0]) begin
        rb_block_q <= wdata_q[`FCC_CTRL_RB_BLOCK];
        recfg_q <= wdata_q[`FCC_CTRL_RECFG];
      end else if (st_q != ST_RUN) begin
        recfg_q <= 1'b0;
      end
    end
  end

  // Read channel, one access at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FCC_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `FCC_OFS_CTRL: s_axi_rdata <= {30'h0, recfg_q, rb_block_q};
        `FCC_OFS_STAT: s_axi_rdata <= {22'h0, rb_used_q, pd, configured,
                                       mode_q, 4'(st_q)};
        `FCC_OFS_RBCNT: s_axi_rdata <= {16'h0, rbcnt_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FCC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// file: testbench/fcc_host_model.sv
module fcc_host_model (
  // Resolved pins
  input wire logic config_clock_wire,
  input wire logic m1_wire,
  // Host drives
  output logic clk_q,
  output logic clk_oe,
  output logic data_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock parked high, released until a transfer needs it
  initial begin
    clk_q = 1'b1;
    clk_oe = 1'b0;
    data_q = 1'b0;
  end

  // Bitstream on own clock (slave) or on the device clock
  task automatic load(input logic [7:0] bits, input int n, input bit own);
    #7;
    clk_oe = own;
    for (int i = 0; i < n; i++) begin
      data_q = bits[i];
      if (own) begin
        clk_q = 1'b0;
        #100 clk_q = 1'b1;
        #100;
      end else begin
        @(posedge config_clock_wire);
        #100;
      end
    end
    clk_oe = 1'b0;
    data_q = ~data_q; // Stale level must not pass as data
  endtask

  // Readback: sample the active-low line late in each low phase
  task automatic rdbk(output logic [7:0] got);
    #7;
    clk_oe = 1'b1;
    for (int i = 0; i < 8; i++) begin
      clk_q = 1'b0;
      #100 got[i] = ~m1_wire;
      clk_q = 1'b1;
      #100;
    end
    clk_oe = 1'b0;
  endtask
endmodule

// file: testbench/fcc_top_monitor.sv
module fcc_top_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pins
  input wire logic power_down_n,
  input wire logic config_reset_n,
  input wire logic mode0_read_trigger,
  input wire logic mode_line_2,
  input wire logic mode_line_1_in,
  input wire logic mode_line_1_oe,
  input wire logic config_clock_oe,
  input wire logic config_clock_pullup_en,
  input wire logic done_program_pin_out,
  input wire logic done_program_pin_oe,
  input wire logic io_block_out_en,
  input wire logic storage_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_done_io;
    $fell(done_program_pin_oe) |-> io_block_out_en && $past(io_block_out_en);
  endproperty
  a_done_io: assert property (p_done_io) else $error("done before outputs");
  // Power-down release excluded: outputs return while done is still held
  property p_done_step;
    $rose(io_block_out_en) && $past(power_down_n, 4) |=> $fell(done_program_pin_oe);
  endproperty
  a_done_step: assert property (p_done_step) else $error("done step wrong");
  // Margin of four edges covers the two sync flops
  property p_pd_float;
    !power_down_n [*4] |-> storage_clear && !mode_line_1_oe && !config_clock_oe
      && !io_block_out_en;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("power-down not quiet");
  property p_pd_hold;
    $rose(power_down_n) |-> ##5 done_program_pin_oe [*8] ##60 done_program_pin_oe
      ##[8:20] !done_program_pin_oe;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("done hold wrong");
  property p_pullup;
    config_clock_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("clock pull-up off");
  property p_open_drain;
    !done_program_pin_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("done driven high");
  property p_rst_clear;
    !config_reset_n [*5] |-> storage_clear;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("storage not cleared");
  property p_rst_hold;
    !config_reset_n [*6] |-> !config_clock_oe;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("load under reset");
  property p_clk_mode;
    config_clock_oe |-> !(mode_line_2 && mode_line_1_in && mode0_read_trigger);
  endproperty
  a_clk_mode: assert property (p_clk_mode) else $error("clock driven in slave");
  property p_rb_cfg;
    mode_line_1_oe |-> !done_program_pin_oe && !config_clock_oe;
  endproperty
  a_rb_cfg: assert property (p_rb_cfg) else $error("readback unconfigured");
  property p_rvalid;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer late");
endmodule

bind fcc_top fcc_top_monitor u_mon (.*);

// file: testbench/fcc_top_tb_top.sv
`include "fcc_params.svh"

module fcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fcc_pkg::*;
  logic aclk, aresetn, power_down_n, config_reset_n, mode0_read_trigger, mode_line_2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, m1_drv, prog_n, h_clk, h_oe;
  logic [7:0] s_axi_awaddr, s_axi_araddr, got;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic mode_line_1_out, mode_line_1_oe, config_clock_out, config_clock_oe, config_data_in;
  logic config_clock_pullup_en, done_program_pin_out, done_program_pin_oe, done_pullup_en;
  logic io_block_out_en, storage_clear;
  int n_mismatch, comparisons, cycles, n;
  // Wires resolved from all enables; pull-ups where nobody drives
  wire logic config_clock_in = config_clock_oe ? config_clock_out : (h_oe ? h_clk : 1'b1);
  wire logic mode_line_1_in = mode_line_1_oe ? mode_line_1_out : m1_drv;
  wire logic done_program_pin_in = (done_program_pin_oe ? done_program_pin_out : 1'b1) & prog_n;
  localparam logic [7:0] BITS_A = 8'hA5; // Single readback, done pull-up on
  localparam logic [7:0] BITS_B = 8'h58; // Repeated readback, pull-up off
  localparam logic [7:0] BITS_C = 8'h06; // Readback off, pull-up on

  fcc_top #(.CFG_BITS(8), .POR_CYC(20)) DUT (.*);
  fcc_host_model u_host (.config_clock_wire(config_clock_in), .m1_wire(mode_line_1_in), .clk_q(h_clk),
    .clk_oe(h_oe), .data_q(config_data_in));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Hang guard, well above the expected run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    st = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic trig();
    @(posedge aclk);
    mode0_read_trigger <= 1'b0;
    repeat (4) @(posedge aclk);
    mode0_read_trigger <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask

  // At least eight cycles, so a done still released from before is skipped
  task automatic wait_done();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (n < 8 || done_program_pin_in !== 1'b1);
  endtask

  task automatic tdone(input string s);
    $display("test %s ended, %0d mismatches so far", s, n_mismatch);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {aresetn, config_reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {power_down_n, prog_n, s_axi_wstrb} = 6'h3F;
    {mode_line_2, m1_drv, mode0_read_trigger} = MD_SLAVE;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_bit("done low", 1'b1, done_program_pin_oe);
    chk_bit("outputs", 1'b0, io_block_out_en);
    chk_bit("clear", 1'b1, storage_clear);
    chk_bit("done pull-up", 1'b1, done_pullup_en);
    repeat (60) @(posedge aclk);
    axi_rd(`FCC_OFS_STAT);
    chk_word("state", 32'h1, {28'h0, st[3:0]});
    config_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    u_host.load(BITS_A, 4, 1'b1);
    @(posedge aclk);
    config_reset_n <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_rd(`FCC_OFS_STAT);
    chk_word("state", 32'h1, {28'h0, st[3:0]});
    config_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    u_host.load(BITS_A, 8, 1'b1);
    wait_done();
    chk_bit("outputs", 1'b1, io_block_out_en);
    chk_bit("done pull-up", 1'b1, done_pullup_en);
    axi_rd(`FCC_OFS_STAT);
    chk_word("status", 32'hF6, st & 32'hFF);
    trig();
    u_host.rdbk(got);
    chk_word("readback", {24'h0, BITS_A}, {24'h0, got});
    trig();
    chk_bit("second readback", 1'b0, mode_line_1_oe);
    axi_rd(`FCC_OFS_RBCNT);
    chk_word("readbacks", 32'h1, st);
    axi_rd(8'h0C);
    chk_word("unmapped", {30'h0, `FCC_RESP_SLVERR}, {30'h0, rsp});
    chk_word("unmapped data", 32'h0, st);
    tdone("slave load");
    power_down_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk_bit("clear", 1'b1, storage_clear);
    power_down_n <= 1'b1;
    wait_done();
    chk_bit("done hold", 1'b1, n >= 80 && n <= 88);
    axi_rd(`FCC_OFS_STAT);
    chk_bit("configured", 1'b1, st[7]);
    tdone("power-down");
    {mode_line_2, m1_drv, mode0_read_trigger} <= MD_MASTER_LOW;
    prog_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_bit("clear", 1'b1, storage_clear);
    prog_n <= 1'b1;
    u_host.load(BITS_B, 8, 1'b0);
    wait_done();
    chk_bit("done pull-up", 1'b0, done_pullup_en);
    axi_rd(`FCC_OFS_STAT);
    chk_word("status", 32'hC6, st & 32'hFF);
    for (int i = 0; i < 2; i++) begin
      trig();
      u_host.rdbk(got);
      chk_word("readback", {24'h0, BITS_B}, {24'h0, got});
    end
    axi_wr(`FCC_OFS_CTRL, 32'h1);
    chk_word("write resp", {30'h0, `FCC_RESP_OKAY}, {30'h0, rsp});
    axi_rd(`FCC_OFS_CTRL);
    chk_word("control", 32'h1, st);
    trig();
    chk_bit("blocked readback", 1'b0, mode_line_1_oe);
    config_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk_bit("clear", 1'b1, storage_clear);
    tdone("master reload");
    // Reconfigure from the register, trigger line left high: peripheral mode
    config_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_wr(`FCC_OFS_CTRL, 32'h2);
    u_host.load(BITS_C, 8, 1'b0);
    wait_done();
    axi_rd(`FCC_OFS_STAT);
    chk_word("status", 32'hD6, st & 32'hFF);
    trig();
    chk_bit("readback off", 1'b0, mode_line_1_oe);
    chk_bit("done pull-up", 1'b1, done_pullup_en);
    tdone("option off");
    final_report();
  end
endmodule
